// ===== verilog/porbs_pkg.sv
/*
 * Shared constants for the power-on, reset escalation and boot select block:
 * timing figures, derived cycle counts, register map and encodings.
 * Assumes a single 40 MHz clock that runs while the block is supplied.
 */
package porbs_pkg;

    localparam longint unsigned CLK_HZ        = 64'd40_000_000;
    localparam int              CNT_W         = 33;

    // Times in microseconds, as the hardware specifies them
    localparam longint unsigned DEBOUNCE_US   = 64'd16_000;
    localparam longint unsigned STAGE1_US     = 64'd10_256_000;
    localparam longint unsigned STAGE2_US     = 64'd2_000_000;
    localparam longint unsigned STAGE3_US     = 64'd128_000_000;
    localparam longint unsigned RST_HOLD_US   = 64'd200;

    // Least time rounded up to whole cycles, never below one
    function automatic longint unsigned cyc_of_us(input longint unsigned us);
        longint unsigned c;
        c = (us * CLK_HZ + 64'd999_999) / 64'd1_000_000;
        return (c == 64'd0) ? 64'd1 : c;
    endfunction

    localparam longint unsigned DEBOUNCE_CYC  = cyc_of_us(DEBOUNCE_US);
    localparam longint unsigned STAGE1_CYC    = cyc_of_us(STAGE1_US);
    localparam longint unsigned STAGE2_CYC    = cyc_of_us(STAGE2_US);
    localparam longint unsigned STAGE3_CYC    = cyc_of_us(STAGE3_US);
    localparam longint unsigned RST_HOLD_CYC  = cyc_of_us(RST_HOLD_US);

    // Register map (byte addresses)
    localparam int              ADDR_W        = 4;
    localparam logic [3:0]      REG_CTRL      = 4'h0;
    localparam logic [3:0]      REG_STATUS    = 4'h4;
    localparam logic [3:0]      REG_BOOT      = 4'h8;

    localparam int              CTRL_TYPE_BIT = 0;
    localparam int              CTRL_ACK_BIT  = 4;
    localparam logic            CTRL_TYPE_RST = 1'h0;

    localparam int              ST_STATE_LSB  = 0;
    localparam int              ST_BARK_BIT   = 4;
    localparam int              ST_BITE_BIT   = 5;
    localparam int              ST_HARD_BIT   = 6;
    localparam int              ST_KEY_BIT    = 7;
    localparam int              ST_RSTIN_BIT  = 8;

    localparam int              FAST_W        = 15;
    localparam int              BOOT_FAST_LSB = 0;
    localparam int              BOOT_USB_BIT  = 15;
    localparam int              BOOT_WDOG_BIT = 16;
    localparam int              BOOT_ORD_LSB  = 17;

    typedef enum logic [3:0] {
        PS_OFF   = 4'h1,
        PS_RESET = 4'h2,
        PS_RUN   = 4'h4,
        PS_BARK  = 4'h8
    } porbs_state_t;

    typedef enum logic {
        BITE_RESET    = 1'h0,
        BITE_SHUTDOWN = 1'h1
    } porbs_bite_t;

    typedef enum logic [2:0] {
        BOOT_A_B_USB = 3'h0,
        BOOT_B_A     = 3'h1,
        BOOT_A_ONLY  = 3'h2,
        BOOT_USB     = 3'h3,
        BOOT_FORCED  = 3'h4
    } porbs_boot_t;

endpackage

// ===== verilog/porbs_trig_if.sv
/*
 * Carrier between the top module and one reset trigger filter.
 * Assumes both ends sit on the same clock.
 */
interface porbs_trig_if;
    logic active;
    logic held;
    logic expired;

    modport filt (input active, output held, output expired);
    modport user (output active, input held, input expired);
endinterface

// ===== verilog/porbs_trig_filter.sv
/*
 * Debounce and delay timer for one reset trigger input.
 * Assumes the active level is already synchronous to mclk.
 */
module porbs_trig_filter #(
    parameter longint unsigned DEB_CYC = porbs_pkg::DEBOUNCE_CYC,
    parameter longint unsigned DLY_CYC = porbs_pkg::STAGE1_CYC
) (
    input wire logic       mclk,
    input wire logic       resetn,
    porbs_trig_if.filt     tif
);
    import porbs_pkg::*;

    logic [CNT_W-1:0] debCnt_r;
    logic [CNT_W-1:0] dlyCnt_r;
    logic             held_r;
    logic             expired_r;

    // A level change must hold for the whole debounce window
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            debCnt_r <= '0;
            held_r   <= 1'b0;
        end else if (tif.active == held_r) begin
            debCnt_r <= '0;
        end else if (debCnt_r == CNT_W'(DEB_CYC - 64'd1)) begin
            debCnt_r <= '0;
            held_r   <= tif.active;
        end else begin
            debCnt_r <= debCnt_r + CNT_W'(1);
        end
    end

    // Delay timer restarts on every release
    always_ff @(posedge mclk) begin
        if (!resetn || !held_r) begin
            dlyCnt_r  <= '0;
            expired_r <= 1'b0;
        end else if (dlyCnt_r == CNT_W'(DLY_CYC - 64'd1)) begin
            expired_r <= 1'b1;
        end else begin
            dlyCnt_r <= dlyCnt_r + CNT_W'(1);
        end
    end

    assign tif.held    = held_r;
    assign tif.expired = expired_r;
endmodule

// ===== verilog/porbs_top.sv
/*
 * Power-on detection, three-stage reset escalation and boot select latch.
 * Assumes synchronous pin inputs, a free running mclk and fuse values that
 * are stable while reset_out_n is low.
 */
module porbs_top
#(
    parameter longint unsigned DEBOUNCE_CYC = porbs_pkg::DEBOUNCE_CYC,
    parameter longint unsigned STAGE1_CYC   = porbs_pkg::STAGE1_CYC,
    parameter longint unsigned STAGE2_CYC   = porbs_pkg::STAGE2_CYC,
    parameter longint unsigned STAGE3_CYC   = porbs_pkg::STAGE3_CYC,
    parameter longint unsigned RST_HOLD_CYC = porbs_pkg::RST_HOLD_CYC
) (
    input  wire logic                          mclk,
    input  wire logic                          resetn,
    input  wire logic                          powerKeyN,
    input  wire logic                          levelPowerOnIn,
    input  wire logic                          pmicResetInN,
    input  wire logic [3:0]                    bootSelectStraps,
    input  wire logic [porbs_pkg::FAST_W-1:4]  extBootStraps,
    input  wire logic                          overrideStrapPin,
    input  wire logic                          overrideKillFuse,
    input  wire logic                          fuseBootBlown,
    input  wire logic [porbs_pkg::FAST_W-1:0]  fuseFastBoot,
    input  wire logic [porbs_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [31:0]                   regWdata,
    input  wire logic                          regWr,
    input  wire logic                          regRd,
    output logic      [31:0]                   regRdata,
    output logic                               powerEnable,
    output logic                               resetOutN,
    output logic                               barkIrq,
    output logic                               strapSampleEn,
    output logic      [porbs_pkg::FAST_W-1:0]  fastBootField,
    output logic                               watchdogOff,
    output logic                               forcedUsbBoot,
    output porbs_pkg::porbs_boot_t             bootOrder
);
    import porbs_pkg::*;

    porbs_trig_if keyIf ();
    porbs_trig_if rstIf ();

    porbs_state_t     state_r;
    porbs_state_t     state_nxt;
    logic [CNT_W-1:0] stage2Cnt_r;
    logic [CNT_W-1:0] stage3Cnt_r;
    logic [CNT_W-1:0] holdCnt_r;
    logic             keyHeldD_r;
    logic             expiredD_r;
    logic             biteType_r;
    logic             barkSeen_r;
    logic             biteSeen_r;
    logic             hardSeen_r;
    logic [31:0]      regRdata_r;
    logic             powerEnable_r;
    logic             resetOutN_r;
    logic             barkIrq_r;
    logic             strapSampleEn_r;
    logic [FAST_W-1:0] fastBoot_r;
    logic             watchdogOff_r;
    logic             forcedUsb_r;
    porbs_boot_t      bootOrder_r;

    logic             keyRelease;
    logic             powerOnReq;
    logic             anyHeld;
    logic             expiredRise;
    logic             stage2Done;
    logic             stage3Done;
    logic             holdDone;
    logic             ackWr;
    logic             statusWr;
    logic [FAST_W-1:0] strapField;
    logic [FAST_W-1:0] bootField;

    assign keyIf.active = ~powerKeyN;
    assign rstIf.active = ~pmicResetInN;

    porbs_trig_filter #(
        .DEB_CYC (DEBOUNCE_CYC),
        .DLY_CYC (STAGE1_CYC)
    ) u_keyFilter (
        .mclk    (mclk),
        .resetn  (resetn),
        .tif     (keyIf)
    );

    porbs_trig_filter #(
        .DEB_CYC (DEBOUNCE_CYC),
        .DLY_CYC (STAGE1_CYC)
    ) u_rstFilter (
        .mclk    (mclk),
        .resetn  (resetn),
        .tif     (rstIf)
    );

    assign keyRelease  = keyHeldD_r & ~keyIf.held;
    assign powerOnReq  = keyRelease | levelPowerOnIn;
    assign anyHeld     = keyIf.held | rstIf.held;
    assign expiredRise = (keyIf.expired | rstIf.expired) & ~expiredD_r;
    assign stage2Done  = (state_r == PS_BARK) && (stage2Cnt_r == CNT_W'(STAGE2_CYC - 64'd1));
    assign stage3Done  = (state_r == PS_RUN || state_r == PS_BARK) &&
                         (stage3Cnt_r == CNT_W'(STAGE3_CYC - 64'd1));
    assign holdDone    = (state_r == PS_RESET) &&
                         (holdCnt_r == CNT_W'(RST_HOLD_CYC - 64'd1));
    assign ackWr       = regWr && regAddr == REG_CTRL && regWdata[CTRL_ACK_BIT];
    assign statusWr    = regWr && regAddr == REG_STATUS;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            keyHeldD_r <= 1'b0;
            expiredD_r <= 1'b0;
        end else begin
            keyHeldD_r <= keyIf.held;
            expiredD_r <= keyIf.expired | rstIf.expired;
        end
    end

    // Stage three always wins over stage two when both end together
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PS_OFF: begin
                if (powerOnReq) begin
                    state_nxt = PS_RESET;
                end
            end
            PS_RESET: begin
                if (holdDone) begin
                    state_nxt = PS_RUN;
                end
            end
            PS_RUN: begin
                if (stage3Done) begin
                    state_nxt = PS_RESET;
                end else if (expiredRise) begin
                    state_nxt = PS_BARK;
                end
            end
            PS_BARK: begin
                if (stage3Done) begin
                    state_nxt = PS_RESET;
                end else if (stage2Done) begin
                    state_nxt = (biteType_r == BITE_SHUTDOWN) ? PS_OFF : PS_RESET;
                end else if (ackWr || !anyHeld) begin
                    state_nxt = PS_RUN;
                end
            end
            default: begin
                state_nxt = PS_OFF;
            end
        endcase
    end

    // Only PS_OFF looks at power-on triggers, so a powered system ignores them
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_r <= PS_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Stage two only starts after stage one has expired
    always_ff @(posedge mclk) begin
        if (!resetn || state_r != PS_BARK) begin
            stage2Cnt_r <= '0;
        end else if (!stage2Done) begin
            stage2Cnt_r <= stage2Cnt_r + CNT_W'(1);
        end
    end

    // Shared by both triggers and free of the stage one/two chain
    always_ff @(posedge mclk) begin
        if (!resetn || !anyHeld || stage3Done ||
            !(state_r == PS_RUN || state_r == PS_BARK)) begin
            stage3Cnt_r <= '0;
        end else begin
            stage3Cnt_r <= stage3Cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn || state_r != PS_RESET) begin
            holdCnt_r <= '0;
        end else if (!holdDone) begin
            holdCnt_r <= holdCnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            powerEnable_r   <= 1'b0;
            resetOutN_r     <= 1'b0;
            strapSampleEn_r <= 1'b0;
            barkIrq_r       <= 1'b0;
        end else begin
            powerEnable_r   <= state_nxt != PS_OFF;
            resetOutN_r     <= state_nxt == PS_RUN || state_nxt == PS_BARK;
            strapSampleEn_r <= state_nxt == PS_RESET;
            barkIrq_r       <= state_nxt == PS_BARK;
        end
    end

    // Boot field assembly from straps, or from fuses once programmed
    always_comb begin
        strapField      = '0;
        strapField[2:0] = bootSelectStraps[3:1];
        strapField[3]   = bootSelectStraps[0];
        strapField[FAST_W-1:4] = extBootStraps;
        bootField       = fuseBootBlown ? fuseFastBoot : strapField;
    end

    // Captured on the same edge on which reset_out_n rises
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            fastBoot_r    <= '0;
            watchdogOff_r <= 1'b0;
            forcedUsb_r   <= 1'b0;
            bootOrder_r   <= BOOT_A_B_USB;
        end else if (holdDone) begin
            fastBoot_r    <= bootField;
            watchdogOff_r <= bootSelectStraps[1];
            forcedUsb_r   <= overrideStrapPin & ~overrideKillFuse;
            if (overrideStrapPin && !overrideKillFuse) begin
                bootOrder_r <= BOOT_FORCED;
            end else begin
                case (bootField[2:0])
                    3'h1: bootOrder_r <= BOOT_B_A;
                    3'h2: bootOrder_r <= BOOT_A_ONLY;
                    3'h3: bootOrder_r <= BOOT_USB;
                    default: bootOrder_r <= BOOT_A_B_USB;
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            biteType_r <= CTRL_TYPE_RST;
        end else if (regWr && regAddr == REG_CTRL) begin
            biteType_r <= regWdata[CTRL_TYPE_BIT];
        end
    end

    // Sticky event flags: write one clears, a same-cycle event wins
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            barkSeen_r <= 1'b0;
            biteSeen_r <= 1'b0;
            hardSeen_r <= 1'b0;
        end else begin
            barkSeen_r <= (state_nxt == PS_BARK && state_r == PS_RUN) |
                          (barkSeen_r & ~(statusWr & regWdata[ST_BARK_BIT]));
            biteSeen_r <= (stage2Done & ~stage3Done) |
                          (biteSeen_r & ~(statusWr & regWdata[ST_BITE_BIT]));
            hardSeen_r <= stage3Done |
                          (hardSeen_r & ~(statusWr & regWdata[ST_HARD_BIT]));
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn || !regRd) begin
            regRdata_r <= '0;
        end else begin
            regRdata_r <= '0;
            case (regAddr)
                REG_CTRL: regRdata_r[CTRL_TYPE_BIT] <= biteType_r;
                REG_STATUS: begin
                    regRdata_r[ST_STATE_LSB +: 4] <= state_r;
                    regRdata_r[ST_BARK_BIT]       <= barkSeen_r;
                    regRdata_r[ST_BITE_BIT]       <= biteSeen_r;
                    regRdata_r[ST_HARD_BIT]       <= hardSeen_r;
                    regRdata_r[ST_KEY_BIT]        <= keyIf.held;
                    regRdata_r[ST_RSTIN_BIT]      <= rstIf.held;
                end
                REG_BOOT: begin
                    regRdata_r[BOOT_FAST_LSB +: FAST_W] <= fastBoot_r;
                    regRdata_r[BOOT_USB_BIT]            <= forcedUsb_r;
                    regRdata_r[BOOT_WDOG_BIT]           <= watchdogOff_r;
                    regRdata_r[BOOT_ORD_LSB +: 3]       <= bootOrder_r;
                end
                default: regRdata_r <= '0;
            endcase
        end
    end

    assign regRdata      = regRdata_r;
    assign powerEnable   = powerEnable_r;
    assign resetOutN     = resetOutN_r;
    assign barkIrq       = barkIrq_r;
    assign strapSampleEn = strapSampleEn_r;
    assign fastBootField = fastBoot_r;
    assign watchdogOff   = watchdogOff_r;
    assign forcedUsbBoot = forcedUsb_r;
    assign bootOrder     = bootOrder_r;

    a_key_power_on: assert property (@(posedge mclk) disable iff (!resetn)
        state_r == PS_OFF && keyRelease |=> state_r == PS_RESET ##1 !resetOutN_r)
        else $error("key release did not start power-on");

    a_level_power_on: assert property (@(posedge mclk) disable iff (!resetn)
        state_r == PS_OFF && levelPowerOnIn |=> powerEnable_r && state_r == PS_RESET)
        else $error("level input did not start power-on");

    a_bark_irq: assert property (@(posedge mclk) disable iff (!resetn)
        state_r == PS_RUN && expiredRise && !stage3Done |=> barkIrq_r && barkSeen_r)
        else $error("stage one expiry raised no interrupt");

    a_bite_type: assert property (@(posedge mclk) disable iff (!resetn)
        stage2Done && !stage3Done |=>
            (biteType_r == BITE_SHUTDOWN) ? !powerEnable_r : !resetOutN_r && powerEnable_r)
        else $error("stage two bite ignored its type");

    a_stage3_first: assert property (@(posedge mclk) disable iff (!resetn)
        stage3Done |=> state_r == PS_RESET && !resetOutN_r && powerEnable_r && hardSeen_r)
        else $error("stage three did not force a reset");

    a_strap_sample: assert property (@(posedge mclk) disable iff (!resetn)
        strapSampleEn_r == (state_r == PS_RESET))
        else $error("strap sampling window wrong");

    a_strap_latch: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(resetOutN_r) && !$past(fuseBootBlown) |->
            fastBoot_r[2:0] == $past(bootSelectStraps[3:1]) &&
            watchdogOff_r == $past(bootSelectStraps[1]))
        else $error("straps not latched at reset release");

    a_forced_usb: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(resetOutN_r) |->
            (bootOrder_r == BOOT_FORCED) == $past(overrideStrapPin && !overrideKillFuse))
        else $error("override strap handling wrong");

    a_no_restart: assert property (@(posedge mclk) disable iff (!resetn)
        state_r == PS_RUN && !stage3Done |=> state_r != PS_RESET && resetOutN_r)
        else $error("running system restarted without a bite");

    c_key_power: cover property (@(posedge mclk) disable iff (!resetn)
        state_r == PS_OFF && keyRelease);
    c_bark_ack: cover property (@(posedge mclk) disable iff (!resetn)
        state_r == PS_BARK && ackWr);
    c_bite: cover property (@(posedge mclk) disable iff (!resetn)
        stage2Done && !stage3Done);
    c_stage3: cover property (@(posedge mclk) disable iff (!resetn) stage3Done);
endmodule

// ===== test/porbs_board_model.sv
/*
 * Board side of the block: power key, level power-on, reset-in, straps and fuses.
 * Assumes the bench calls its tasks and that mclk is the block's clock.
 */
module porbs_board_model (
    input  wire logic   mclk,
    input  wire logic   strapSampleEn,
    output logic        powerKeyN,
    output logic        levelPowerOnIn,
    output logic        pmicResetInN,
    output logic [3:0]  bootSelectStraps,
    output logic [14:4] extBootStraps,
    output logic        overrideStrapPin,
    output logic        overrideKillFuse,
    output logic        fuseBootBlown,
    output logic [14:0] fuseFastBoot
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] cfg;
    logic        wiggle;
    initial begin
        powerKeyN = 1'b1;
        levelPowerOnIn = 1'b0;
        pmicResetInN = 1'b1;
        cfg = 16'h0000;
        wiggle = 1'b0;
        overrideKillFuse = 1'b0;
        fuseBootBlown = 1'b0;
        fuseFastBoot = 15'h0000;
    end
    always @(posedge mclk) wiggle <= ~wiggle;
    // Released straps are plain GPIO and keep toggling, so a late latch is seen
    assign bootSelectStraps = strapSampleEn ? cfg[3:0] : ~cfg[3:0] ^ {4{wiggle}};
    assign extBootStraps    = strapSampleEn ? cfg[14:4] : ~cfg[14:4] ^ {11{wiggle}};
    assign overrideStrapPin = strapSampleEn ? cfg[15] : wiggle;
    task automatic set_boot(input logic [15:0] s, input logic k, input logic b,
                            input logic [14:0] f);
        cfg <= s;
        overrideKillFuse <= k;
        fuseBootBlown <= b;
        fuseFastBoot <= f;
    endtask
    // Key and reset-in are separate lines with their own timing
    task automatic drive(input int w, input logic v);
        @(posedge mclk);
        case (w)
            0: powerKeyN <= v;
            1: pmicResetInN <= v;
            default: levelPowerOnIn <= v;
        endcase
    endtask
endmodule

// ===== test/power_on_reset_boot_select_tb.sv
/*
 * Self-checking bench for porbs_top with shortened timer counts.
 * Assumes the board model drives every pin input; bench owns the register port.
 */
module power_on_reset_boot_select_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import porbs_pkg::*;
    localparam int DEB = 4, S1 = 20, S2 = 10, S3 = 40, HOLD = 5;
    logic mclk = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0, regRdata, d;
    logic powerEnable, resetOutN, barkIrq, strapSampleEn, watchdogOff, forcedUsbBoot;
    logic [14:0] fastBootField;
    porbs_boot_t bootOrder;
    wire logic powerKeyN, levelPowerOnIn, pmicResetInN, overrideStrapPin;
    wire logic overrideKillFuse, fuseBootBlown;
    wire logic [3:0] bootSelectStraps;
    wire logic [14:4] extBootStraps;
    wire logic [14:0] fuseFastBoot;
    int miscompares = 0, n_tests = 0, n;
    time t0;
    always #12.5 mclk = ~mclk;
    porbs_board_model u_board (.mclk, .strapSampleEn, .powerKeyN, .levelPowerOnIn,
        .pmicResetInN, .bootSelectStraps, .extBootStraps, .overrideStrapPin,
        .overrideKillFuse, .fuseBootBlown, .fuseFastBoot);
    porbs_top #(.DEBOUNCE_CYC(DEB), .STAGE1_CYC(S1), .STAGE2_CYC(S2), .STAGE3_CYC(S3),
        .RST_HOLD_CYC(HOLD)) u_dut (.mclk, .resetn, .powerKeyN, .levelPowerOnIn,
        .pmicResetInN, .bootSelectStraps, .extBootStraps, .overrideStrapPin,
        .overrideKillFuse, .fuseBootBlown, .fuseFastBoot, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .powerEnable, .resetOutN, .barkIrq, .strapSampleEn,
        .fastBootField, .watchdogOff, .forcedUsbBoot, .bootOrder);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask
    function automatic logic pick(input int w);
        return (w == 0) ? powerEnable : (w == 1) ? resetOutN : barkIrq;
    endfunction
    // Bounded wait; the count of edges is handed back for timing checks
    task automatic wait_on(input int w, input logic v, input int lim, output int c);
        c = 0;
        while (pick(w) !== v && c < lim) begin
            @(posedge mclk);
            #1 c++;
        end
        chk(pick(w), v);
    endtask
    task automatic t_level_on;
        u_board.set_boot(16'h0006, 1'b0, 1'b0, 15'h0);
        u_board.drive(2, 1'b1);
        @(posedge mclk);
        #1 chk({powerEnable, strapSampleEn, resetOutN}, 3'b110);
        wait_on(1, 1'b1, HOLD + 4, n);
        repeat (4) @(posedge mclk);
        #1 chk(fastBootField, 15'h0003);
        chk({watchdogOff, bootOrder}, {1'b1, BOOT_USB});
        u_board.drive(0, 1'b0);
        repeat (DEB + 2) @(posedge mclk);
        u_board.drive(0, 1'b1);
        // Long enough for the debounced release to reach the state machine
        repeat (DEB + 4) @(posedge mclk);
        #1 chk({powerEnable, resetOutN}, 2'b11);
        $display("level power-on test done");
    endtask
    task automatic t_bite;
        // Reset-type bite first, then the shutdown type
        u_board.drive(1, 1'b0);
        wait_on(2, 1'b1, 60, n);
        wait_on(1, 1'b0, 30, n);
        chk(n >= S2 - 1 && n <= S2 + 2, 1'b1);
        chk(powerEnable, 1'b1);
        u_board.drive(1, 1'b1);
        reg_wr(REG_CTRL, 32'h1);
        u_board.drive(2, 1'b0);
        u_board.drive(1, 1'b0);
        wait_on(2, 1'b1, 60, n);
        chk(n >= S1 && n <= S1 + DEB + 4, 1'b1);
        wait_on(0, 1'b0, 30, n);
        chk(n >= S2 - 1 && n <= S2 + 2, 1'b1);
        u_board.drive(1, 1'b1);
        reg_rd(REG_STATUS, d);
        chk(d & 32'h3f, 32'h31);
        $display("bark and bite test done");
    endtask
    task automatic t_key_on;
        u_board.drive(0, 1'b0);
        repeat (DEB + 3) @(posedge mclk);
        #1 chk(powerEnable, 1'b0);
        u_board.drive(0, 1'b1);
        wait_on(0, 1'b1, 10, n);
        wait_on(1, 1'b1, HOLD + 4, n);
        $display("key power-on test done");
    endtask
    task automatic t_stage3;
        reg_wr(REG_STATUS, 32'h70);
        u_board.drive(0, 1'b0);
        t0 = $time;
        wait_on(2, 1'b1, 60, n);
        reg_wr(REG_CTRL, 32'h11);
        @(posedge mclk);
        #1 chk(barkIrq, 1'b0);
        wait_on(1, 1'b0, 60, n);
        n = int'(($time - t0) / 25);
        chk(n >= S3 && n <= S3 + DEB + 6, 1'b1);
        reg_rd(REG_STATUS, d);
        chk(d & 32'h7f, 32'h52);
        u_board.drive(0, 1'b1);
        wait_on(1, 1'b1, HOLD + 6, n);
        $display("stage three test done");
    endtask
    task automatic t_boot_table;
        logic [15:0] s;
        logic [14:0] field;
        porbs_boot_t ord;
        for (int i = 0; i < 11; i++) begin
            s = {1'(i == 8 || i == 9), 11'h5a5, (i < 8) ? {i[2:0], 1'b0} : 4'h4};
            field = (i == 10) ? 15'h2a03 : {s[14:4], s[0], s[3:1]};
            ord = (s[15] && i != 9) ? BOOT_FORCED :
                  (field[2:0] > 3'h3) ? BOOT_A_B_USB : porbs_boot_t'(field[2:0]);
            @(posedge mclk);
            resetn <= 1'b0;
            @(posedge mclk);
            resetn <= 1'b1;
            u_board.set_boot(s, i == 9, i == 10, 15'h2a03);
            u_board.drive(2, 1'b1);
            wait_on(1, 1'b1, HOLD + 6, n);
            chk(bootOrder, ord);
            chk({forcedUsbBoot, fastBootField}, {s[15] && i != 9, field});
            if (i != 10) chk(watchdogOff, s[1]);
            u_board.drive(2, 1'b0);
        end
        reg_rd(REG_BOOT, d);
        chk(d & 32'h000effff, {12'h0, ord, 2'b00, field});
        reg_rd(4'hc, d);
        chk(d, 32'h0);
        $display("boot table test done");
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        t_level_on();
        t_bite();
        t_key_on();
        t_stage3();
        t_boot_table();
        finish_test();
    end
    initial begin
        #(25 * 20000);
        miscompares++;
        finish_test();
    end
endmodule
